// ==== verilog/e1pm_pkg.sv ====
// e1pm_pkg: shared constants and types for the e1 port mode control block
package e1pm_pkg;

    // ********************************************************************
    // enumerations of the configuration choices
    // ********************************************************************
    typedef enum logic [1:0] {
        E1PM_CLK_ADAPTIVE,
        E1PM_CLK_RECOVERED,
        E1PM_CLK_INTERNAL
    } e1pm_clk_sel_type;

    typedef enum logic [1:0] {
        E1PM_LOOP_DISABLE,
        E1PM_LOOP_INTERNAL,
        E1PM_LOOP_EXTERNAL
    } e1pm_loop_type;

    typedef enum logic [1:0] {
        E1PM_LINE_UNFRAMED,
        E1PM_LINE_CRC4_ON,
        E1PM_LINE_CRC4_OFF
    } e1pm_line_type;

    typedef enum logic [1:0] {
        E1PM_OP_TRANSPARENT,
        E1PM_OP_FRACTIONAL,
        E1PM_OP_FRACT_CAS
    } e1pm_op_type;

    // one complete port configuration, moved between clock domains as a word
    typedef struct packed {
        logic             chan_en;
        e1pm_clk_sel_type clk_sel;
        e1pm_loop_type    loop_mode;
        e1pm_line_type    line_type;
        logic [7:0]       idle_code;
        logic             cas_en;
        logic [7:0]       cond_byte;
        logic [3:0]       conditioning_signal_nibble;
        logic             line_en;
        logic [31:0]      ts_map;
    } e1pm_cfg_type;

    // ********************************************************************
    // reset values and frame layout
    // ********************************************************************
    localparam logic [7:0]  E1PM_IDLE_RST      = 8'h7E;
    localparam logic [7:0]  E1PM_COND_BYTE_RST = 8'hFF;
    localparam logic [3:0]  E1PM_COND_NIB_RST  = 4'h1;
    localparam logic [31:0] E1PM_TS_MAP_RST    = 32'hFFFFFFFF;
    localparam logic [7:0]  E1PM_AIS_BYTE      = 8'hFF;
    localparam logic [4:0]  E1PM_FRAME_TS      = 5'h00;

    localparam e1pm_cfg_type E1PM_CFG_RST = '{
        chan_en                    : 1'b1,
        clk_sel                    : E1PM_CLK_ADAPTIVE,
        loop_mode                  : E1PM_LOOP_DISABLE,
        line_type                  : E1PM_LINE_CRC4_ON,
        idle_code                  : E1PM_IDLE_RST,
        cas_en                     : 1'b1,
        cond_byte                  : E1PM_COND_BYTE_RST,
        conditioning_signal_nibble : E1PM_COND_NIB_RST,
        line_en                    : 1'b1,
        ts_map                     : E1PM_TS_MAP_RST
    };

endpackage

// ==== verilog/e1pm_port_ctrl.sv ====
// e1pm_port_ctrl: mode control and datapath steering for one e1 line port
//
// Summary of operation
// - channel status enabled reports loss of signal; disabled raises no alarm; default enabled
// - transmit clock select: adaptive, recovered receive clock or internal; adaptive by default
// - internal loopback returns packet-side data back toward the packet network
// - internal loopback sends unframed all-ones on e1 transmit, discards e1 receive data
// - external loopback sends e1 receive data back to e1 and still to packets
// - external loopback discards packet-side data, never reaching e1 transmit
// - loopback disabled passes traffic both ways; disabled after reset
// - unframed line type puts framer in pass-through, port in transparent mode
// - crc-4 enabled uses crc-4 multiframe; operating mode follows signaling setting
// - crc-4 disabled drops crc-4 multiframing; operating mode still follows signaling
// - any line type change disables the line; crc-4 enabled is the default
// - framed modes fill unused transmit timeslots with idle code except in internal loopback, default 7E
// - unframed mode ignores idle code, signaling mode and both conditioning patterns
// - signaling disabled ignores the conditioning signal nibble
// - after reset the conditioning nibble is 1 and conditioning byte FF
// - signaling enabled selects signaling multiframe and fractional-with-signaling operation
// - conditioning byte replaces packet-bound data on line alarms except in internal loopback, e1-bound on buffer faults with loopback disabled
// - unframed conditioning sends all-ones on loss of signal or buffer fault
`timescale 1ns/1ps

module e1pm_port_ctrl
    import e1pm_pkg::*;
(
    // system clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rstn,
    // configuration, sampled on i_cfg_apply
    input  wire logic             i_cfg_apply,
    input  wire logic             i_chan_en,
    input  wire logic [1:0]       i_clk_sel,
    input  wire logic [1:0]       i_loop_mode,
    input  wire logic [1:0]       i_line_type,
    input  wire logic [7:0]       i_idle_code,
    input  wire logic             i_cas_en,
    input  wire logic [7:0]       i_cond_byte,
    input  wire logic [3:0]       i_conditioning_signal_nibble,
    input  wire logic             i_line_en,
    input  wire logic [31:0]      i_ts_map,
    // status in the system domain
    output logic                  o_cfg_busy,
    output logic                  o_los_alarm,
    output logic                  o_line_enabled,
    // line clock domain
    input  wire logic             i_line_clk,
    input  wire logic             i_ts_strobe,
    input  wire logic [4:0]       i_ts_index,
    input  wire logic             i_e1_los,
    input  wire logic             i_e1_lof,
    input  wire logic             i_e1_ais,
    input  wire logic             i_pkt_overrun,
    input  wire logic             i_pkt_underrun,
    input  wire logic [7:0]       i_e1_rx_byte,
    input  wire logic [3:0]       i_e1_rx_sig,
    input  wire logic [7:0]       i_pkt_rx_byte,
    input  wire logic [3:0]       i_pkt_rx_sig,
    // datapath outputs, line clock domain
    output logic                  o_e1_tx_valid,
    output logic [7:0]            o_e1_tx_byte,
    output logic [3:0]            o_e1_tx_sig,
    output logic                  o_pkt_tx_valid,
    output logic [7:0]            o_pkt_tx_byte,
    output logic [3:0]            o_pkt_tx_sig,
    // framer controls, line clock domain
    output logic [1:0]            o_tx_clk_sel,
    output logic [1:0]            o_framer_mode,
    output logic                  o_cas_mf_en,
    output logic [1:0]            o_op_mode
);

    // ********************************************************************
    // system domain: capture and handshake
    // ********************************************************************
    e1pm_cfg_type shadow_q;
    logic         req_tgl_q;
    logic         ack_s1_q;
    logic         ack_s2_q;
    logic         ack_tgl_q;
    logic         los_s1_q;
    logic         los_s2_q;
    logic         len_s1_q;
    logic         len_s2_q;
    logic         los_alarm_q;
    logic         line_en_act_q;

    // busy spans the whole round trip, so a second apply can never tear the word
    assign o_cfg_busy = req_tgl_q ^ ack_s2_q;

    // shadow is only reloaded while no transfer is open, so the line side
    // sees a stable word whenever it samples it
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            shadow_q  <= E1PM_CFG_RST;
            req_tgl_q <= 1'b0;
        end else if (i_cfg_apply && !o_cfg_busy) begin
            shadow_q.chan_en                    <= i_chan_en;
            shadow_q.clk_sel                    <= e1pm_clk_sel_type'(i_clk_sel);
            shadow_q.loop_mode                  <= e1pm_loop_type'(i_loop_mode);
            shadow_q.line_type                  <= e1pm_line_type'(i_line_type);
            shadow_q.idle_code                  <= i_idle_code;
            shadow_q.cas_en                     <= i_cas_en;
            shadow_q.cond_byte                  <= i_cond_byte;
            shadow_q.conditioning_signal_nibble <= i_conditioning_signal_nibble;
            shadow_q.line_en                    <= i_line_en;
            shadow_q.ts_map                     <= i_ts_map;
            req_tgl_q                           <= ~req_tgl_q;
        end
    end

    // acknowledge toggle and line status back into the system domain
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            los_s1_q <= 1'b0;
            los_s2_q <= 1'b0;
            len_s1_q <= 1'b0;
            len_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            los_s1_q <= los_alarm_q;
            los_s2_q <= los_s1_q;
            len_s1_q <= line_en_act_q;
            len_s2_q <= len_s1_q;
        end
    end

    // both status bits are slow levels; a blip shorter than a few line
    // clocks may never show here, which is acceptable for alarm reporting
    assign o_los_alarm    = los_s2_q;
    assign o_line_enabled = len_s2_q;

    // ********************************************************************
    // line domain: receive configuration word
    // ********************************************************************
    logic         req_s1_q;
    logic         req_s2_q;
    logic         req_s3_q;
    logic         rlos_s1_q;
    logic         rlos_s2_q;
    e1pm_cfg_type pend_q;
    logic         pend_vld_q;
    e1pm_cfg_type act_q;
    logic         frame_start;
    logic         take_pend;
    e1pm_cfg_type cfg_use;
    logic         line_ok;

    // toggle request crosses by two flops; third flop only marks the edge
    always_ff @(posedge i_line_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            req_s1_q  <= 1'b0;
            req_s2_q  <= 1'b0;
            req_s3_q  <= 1'b0;
            rlos_s1_q <= 1'b0;
            rlos_s2_q <= 1'b0;
        end else begin
            req_s1_q  <= req_tgl_q;
            req_s2_q  <= req_s1_q;
            req_s3_q  <= req_s2_q;
            rlos_s1_q <= i_e1_los; // analog detector, not on this clock
            rlos_s2_q <= rlos_s1_q;
        end
    end

    assign frame_start = i_ts_strobe && (i_ts_index == E1PM_FRAME_TS);
    assign take_pend   = frame_start && pend_vld_q;
    // the first slot of a new frame already uses the new word
    assign cfg_use     = take_pend ? pend_q : act_q;

    // pending word waits here until the next frame boundary
    always_ff @(posedge i_line_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_q     <= E1PM_CFG_RST;
            pend_vld_q <= 1'b0;
            ack_tgl_q  <= 1'b0;
        end else if (req_s2_q != req_s3_q) begin
            pend_q     <= shadow_q;
            pend_vld_q <= 1'b1;
            ack_tgl_q  <= req_s2_q;
        end else if (take_pend) begin
            pend_vld_q <= 1'b0;
        end
    end

    // active configuration and line enable
    always_ff @(posedge i_line_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            act_q         <= E1PM_CFG_RST;
            line_en_act_q <= 1'b1;
        end else if (take_pend) begin
            act_q <= pend_q;
            if (pend_q.line_type != act_q.line_type) begin
                line_en_act_q <= 1'b0;
            end else begin
                line_en_act_q <= pend_q.line_en;
            end
        end
    end

    // the boundary slot already sees the new enable, so no stale byte slips out
    assign line_ok = take_pend ? (pend_q.line_en && (pend_q.line_type == act_q.line_type))
                               : line_en_act_q;

    // ********************************************************************
    // line domain: alarms and framer controls
    // ********************************************************************
    logic los_det;

    assign los_det = rlos_s2_q && cfg_use.chan_en;

    always_ff @(posedge i_line_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            los_alarm_q <= 1'b0;
        end else begin
            los_alarm_q <= los_det;
        end
    end

    // framer and clock controls follow the active word only
    always_ff @(posedge i_line_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tx_clk_sel  <= E1PM_CLK_ADAPTIVE;
            o_framer_mode <= E1PM_LINE_CRC4_ON;
            o_cas_mf_en   <= 1'b1;
            o_op_mode     <= E1PM_OP_FRACT_CAS;
        end else begin
            o_tx_clk_sel  <= cfg_use.clk_sel;
            o_framer_mode <= cfg_use.line_type;
            if (cfg_use.line_type == E1PM_LINE_UNFRAMED) begin
                o_cas_mf_en <= 1'b0;
                o_op_mode   <= E1PM_OP_TRANSPARENT;
            end else if (cfg_use.cas_en) begin
                o_cas_mf_en <= 1'b1;
                o_op_mode   <= E1PM_OP_FRACT_CAS;
            end else begin
                o_cas_mf_en <= 1'b0;
                o_op_mode   <= E1PM_OP_FRACTIONAL;
            end
        end
    end

    // ********************************************************************
    // line domain: per-timeslot datapath
    // ********************************************************************
    logic       unframed;
    logic       ts_used;
    logic       line_fault;
    logic       buf_fault;
    logic [7:0] e1_byte_d;
    logic [3:0] e1_sig_d;
    logic [7:0] pkt_byte_d;
    logic [3:0] pkt_sig_d;
    logic       pkt_vld_d;

    assign unframed   = (cfg_use.line_type == E1PM_LINE_UNFRAMED);
    assign ts_used    = cfg_use.ts_map[i_ts_index];
    assign line_fault = los_det || (!unframed && (i_e1_lof || i_e1_ais));
    assign buf_fault  = i_pkt_overrun || i_pkt_underrun;

    // steering: the loopback mode picks sources, then conditioning and idle
    // fill overwrite; signaling nibbles are zero whenever signaling is off
    always_comb begin
        e1_byte_d  = i_pkt_rx_byte;
        e1_sig_d   = i_pkt_rx_sig;
        pkt_byte_d = i_e1_rx_byte;
        pkt_sig_d  = i_e1_rx_sig;
        pkt_vld_d  = 1'b1;
        case (cfg_use.loop_mode)
            E1PM_LOOP_INTERNAL: begin
                pkt_byte_d = i_pkt_rx_byte;
                pkt_sig_d  = i_pkt_rx_sig;
                e1_byte_d  = E1PM_AIS_BYTE;
                e1_sig_d   = 4'hF;
            end
            E1PM_LOOP_EXTERNAL: begin
                e1_byte_d = i_e1_rx_byte;
                e1_sig_d  = i_e1_rx_sig;
            end
            default: begin
                e1_byte_d = i_pkt_rx_byte;
            end
        endcase
        // conditioning toward the packet side on line alarms
        if (line_fault && cfg_use.loop_mode != E1PM_LOOP_INTERNAL) begin
            if (unframed) begin
                pkt_byte_d = E1PM_AIS_BYTE;
            end else begin
                pkt_byte_d = cfg_use.cond_byte;
                pkt_sig_d  = cfg_use.conditioning_signal_nibble;
            end
        end
        // conditioning toward the line on packet buffer faults
        if (buf_fault && cfg_use.loop_mode == E1PM_LOOP_DISABLE) begin
            if (unframed) begin
                e1_byte_d = E1PM_AIS_BYTE;
            end else begin
                e1_byte_d = cfg_use.cond_byte;
                e1_sig_d  = cfg_use.conditioning_signal_nibble;
            end
        end
        // idle fill of unassigned slots, never in internal loopback
        if (!unframed && !ts_used && cfg_use.loop_mode != E1PM_LOOP_INTERNAL) begin
            e1_byte_d = cfg_use.idle_code;
            pkt_vld_d = 1'b0;
        end
        if (unframed || !cfg_use.cas_en) begin
            e1_sig_d  = 4'h0;
            pkt_sig_d = 4'h0;
        end
        if (!line_ok) begin
            e1_byte_d = E1PM_AIS_BYTE; // a disabled line keeps the far end alarmed
            pkt_vld_d = 1'b0;
        end
    end

    // one output beat per timeslot strobe
    always_ff @(posedge i_line_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_e1_tx_valid  <= 1'b0;
            o_e1_tx_byte   <= E1PM_AIS_BYTE;
            o_e1_tx_sig    <= 4'h0;
            o_pkt_tx_valid <= 1'b0;
            o_pkt_tx_byte  <= 8'h00;
            o_pkt_tx_sig   <= 4'h0;
        end else begin
            o_e1_tx_valid  <= i_ts_strobe;
            o_pkt_tx_valid <= i_ts_strobe && pkt_vld_d;
            if (i_ts_strobe) begin
                o_e1_tx_byte  <= e1_byte_d;
                o_e1_tx_sig   <= e1_sig_d;
                o_pkt_tx_byte <= pkt_byte_d;
                o_pkt_tx_sig  <= pkt_sig_d;
            end
        end
    end

endmodule

// ==== test/e1pm_assertions.sv ====
// e1pm_assertions: port-level checker for the e1 port mode control block
`timescale 1ns/1ps

module e1pm_assertions
    import e1pm_pkg::*;
(
    // clocks and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_line_clk,
    // configuration handshake
    input  wire logic       i_cfg_apply,
    input  wire logic       o_cfg_busy,
    // timeslot stream
    input  wire logic       i_ts_strobe,
    input  wire logic [4:0] i_ts_index,
    input  wire logic       o_e1_tx_valid,
    input  wire logic [3:0] o_e1_tx_sig,
    input  wire logic       o_pkt_tx_valid,
    input  wire logic [3:0] o_pkt_tx_sig,
    // framer controls
    input  wire logic [1:0] o_tx_clk_sel,
    input  wire logic [1:0] o_framer_mode,
    input  wire logic       o_cas_mf_en,
    input  wire logic [1:0] o_op_mode
);
    // ****************************************************************
    // helper terms
    // ****************************************************************
    // frame start marker, kept as a signal so $past sees a plain name
    logic ts0;
    assign ts0 = i_ts_strobe && (i_ts_index == 5'h00);

    sequence s_apply;
        i_cfg_apply && !o_cfg_busy;
    endsequence
    sequence s_slot;
        i_ts_strobe;
    endsequence

    AST_BUSY_RISE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        s_apply |=> o_cfg_busy) else $error("busy did not follow apply");
    // busy must drop in bounded time or the handshake has hung
    AST_BUSY_BOUND: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(o_cfg_busy) |-> ##[1:60] !o_cfg_busy) else $error("busy stuck high");
    AST_E1_VALID: assert property (@(posedge i_line_clk) disable iff (!i_rstn)
        s_slot |=> o_e1_tx_valid) else $error("no e1 valid after strobe");
    AST_VALID_PULSE: assert property (@(posedge i_line_clk) disable iff (!i_rstn)
        !i_ts_strobe |=> !o_e1_tx_valid && !o_pkt_tx_valid) else $error("stray valid");
    AST_UNFRAMED_OP: assert property (@(posedge i_line_clk) disable iff (!i_rstn)
        o_framer_mode == E1PM_LINE_UNFRAMED |-> o_op_mode == E1PM_OP_TRANSPARENT)
        else $error("unframed not transparent");
    AST_FRAMED_OP: assert property (
        @(posedge i_line_clk) disable iff (!i_rstn)
        o_framer_mode != E1PM_LINE_UNFRAMED |->
        o_op_mode == (o_cas_mf_en ? E1PM_OP_FRACT_CAS : E1PM_OP_FRACTIONAL))
        else $error("operating mode does not follow signaling");
    AST_SIG_QUIET: assert property (
        @(posedge i_line_clk) disable iff (!i_rstn)
        o_e1_tx_valid && !o_cas_mf_en && $past(o_cas_mf_en) == 1'b0 |->
        o_e1_tx_sig == 4'h0 && o_pkt_tx_sig == 4'h0) else $error("signaling not ignored");
    // two-cycle window covers a capture at the strobe plus one register stage
    AST_CFG_AT_BOUNDARY: assert property (@(posedge i_line_clk) disable iff (!i_rstn)
        $changed({o_framer_mode, o_op_mode, o_cas_mf_en, o_tx_clk_sel}) |->
        $past(ts0) || $past(ts0, 2)) else $error("config changed off frame boundary");
endmodule

bind e1pm_port_ctrl e1pm_assertions u_chk (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_line_clk(i_line_clk), .i_cfg_apply(i_cfg_apply), .o_cfg_busy(o_cfg_busy),
    .i_ts_strobe(i_ts_strobe), .i_ts_index(i_ts_index), .o_e1_tx_valid(o_e1_tx_valid),
    .o_e1_tx_sig(o_e1_tx_sig), .o_pkt_tx_valid(o_pkt_tx_valid), .o_pkt_tx_sig(o_pkt_tx_sig),
    .o_tx_clk_sel(o_tx_clk_sel), .o_framer_mode(o_framer_mode), .o_cas_mf_en(o_cas_mf_en),
    .o_op_mode(o_op_mode));

// ==== test/e1pm_line_model.sv ====
// e1pm_line_model: far-side model feeding timeslots and alarm levels
`timescale 1ns/1ps

module e1pm_line_model (
    // line clock
    input  wire logic       i_line_clk,
    // timeslot stream toward the block
    output logic            o_ts_strobe,
    output logic [4:0]      o_ts_index,
    output logic [7:0]      o_e1_byte,
    output logic [3:0]      o_e1_sig,
    output logic [7:0]      o_pkt_byte,
    output logic [3:0]      o_pkt_sig,
    // alarm and buffer levels: los, lof, ais, overrun, underrun
    output logic [4:0]      o_faults
);
    // idle stream until the bench asks for slots
    initial begin
        o_ts_strobe = 1'b0;
        o_ts_index  = 5'h1F;
        o_e1_byte   = 8'h00;
        o_e1_sig    = 4'h0;
        o_pkt_byte  = 8'h00;
        o_pkt_sig   = 4'h0;
        o_faults    = 5'h00;
    end

    // one slot: strobe for a single line cycle, then invert the released
    // lines so stale data can never pass for a fresh sample
    task automatic send(input logic [4:0] idx, input logic [7:0] eb, input logic [3:0] es,
                        input logic [7:0] pb, input logic [3:0] ps);
        @(posedge i_line_clk);
        o_ts_strobe <= 1'b1;
        o_ts_index  <= idx;
        o_e1_byte   <= eb;
        o_e1_sig    <= es;
        o_pkt_byte  <= pb;
        o_pkt_sig   <= ps;
        @(posedge i_line_clk);
        o_ts_strobe <= 1'b0;
        o_ts_index  <= ~idx;
        o_e1_byte   <= ~eb;
        o_e1_sig    <= ~es;
        o_pkt_byte  <= ~pb;
        o_pkt_sig   <= ~ps;
        #1;
    endtask

    // alarm levels settle through the synchronisers before returning
    task automatic set_faults(input logic [4:0] f);
        @(posedge i_line_clk);
        o_faults <= f;
        repeat (6) @(posedge i_line_clk);
    endtask
endmodule

// ==== test/testbench.sv ====
// testbench: directed scenarios for the e1 port mode control block
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("Error %s expected %0h seen %0h", n, e, a); end end

module testbench
    import e1pm_pkg::*;
;
    logic i_ref_clk, i_line_clk, i_rstn, i_cfg_apply, busy, los_alarm, line_on;
    logic e1_v, pkt_v, cas_mf, strobe;
    logic [1:0] clk_sel, fm, op;
    logic [4:0] idx, f;
    logic [7:0] e1_b, pkt_b, rx_e1_b, rx_pkt_b;
    logic [3:0] e1_s, pkt_s, rx_e1_s, rx_pkt_s;
    e1pm_cfg_type c, k;
    int bad_count = 0;
    int total_checks = 0;

    e1pm_port_ctrl dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_cfg_apply(i_cfg_apply),
        .i_chan_en(c.chan_en), .i_clk_sel(c.clk_sel), .i_loop_mode(c.loop_mode),
        .i_line_type(c.line_type), .i_idle_code(c.idle_code), .i_cas_en(c.cas_en),
        .i_cond_byte(c.cond_byte), .i_ts_map(c.ts_map), .i_line_en(c.line_en),
        .i_conditioning_signal_nibble(c.conditioning_signal_nibble),
        .o_cfg_busy(busy), .o_los_alarm(los_alarm), .o_line_enabled(line_on),
        .i_line_clk(i_line_clk), .i_ts_strobe(strobe), .i_ts_index(idx), .i_e1_los(f[4]),
        .i_e1_lof(f[3]), .i_e1_ais(f[2]), .i_pkt_overrun(f[1]), .i_pkt_underrun(f[0]),
        .i_e1_rx_byte(rx_e1_b), .i_e1_rx_sig(rx_e1_s), .i_pkt_rx_byte(rx_pkt_b),
        .i_pkt_rx_sig(rx_pkt_s), .o_e1_tx_valid(e1_v), .o_e1_tx_byte(e1_b),
        .o_e1_tx_sig(e1_s), .o_pkt_tx_valid(pkt_v), .o_pkt_tx_byte(pkt_b),
        .o_pkt_tx_sig(pkt_s), .o_tx_clk_sel(clk_sel), .o_framer_mode(fm),
        .o_cas_mf_en(cas_mf), .o_op_mode(op));

    e1pm_line_model m (.i_line_clk(i_line_clk), .o_ts_strobe(strobe), .o_ts_index(idx),
        .o_e1_byte(rx_e1_b), .o_e1_sig(rx_e1_s), .o_pkt_byte(rx_pkt_b),
        .o_pkt_sig(rx_pkt_s), .o_faults(f));

    // ****************************************************************
    // clocks and watchdog
    // ****************************************************************
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    // odd start offset keeps the link clock out of phase with the system clock
    initial begin
        i_line_clk = 1'b0;
        #7;
        forever #62.5 i_line_clk = ~i_line_clk;
    end
    initial begin
        #100000;
        bad_count++;
        give_verdict();
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one slot with fixed receive data (e1 3C/A, packet 5A/6); x sig skips the check
    task automatic go(input logic [4:0] s, input logic [7:0] eb, input logic [3:0] es,
                      input logic pv, input logic [7:0] pb, input logic [3:0] ps);
        m.send(s, 8'h3C, 4'hA, 8'h5A, 4'h6);
        `CHK("e1_valid", 1'b1, e1_v)
        `CHK("e1_byte", eb, e1_b)
        if (!$isunknown(es)) `CHK("e1_sig", es, e1_s)
        `CHK("pkt_valid", pv, pkt_v)
        if (pv) `CHK("pkt_byte", pb, pkt_b)
        if (pv && !$isunknown(ps)) `CHK("pkt_sig", ps, pkt_s)
    endtask

    // apply a word, wait out the handshake, then open a frame so it takes hold
    task automatic apply(input e1pm_cfg_type nc);
        int n;
        @(posedge i_ref_clk);
        c <= nc;
        i_cfg_apply <= 1'b1;
        @(posedge i_ref_clk);
        i_cfg_apply <= 1'b0;
        #1;
        `CHK("busy", 1'b1, busy)
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        `CHK("busy_done", 1'b0, busy)
        m.send(5'h00, 8'h00, 4'h0, 8'h00, 4'h0);
        // status outputs are launched by this clock: look after the edge
        repeat (6) @(posedge i_ref_clk);
        #1;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        c = E1PM_CFG_RST;
        i_cfg_apply = 1'b0;
        i_rstn = 1'b0;
        // held in slow-clock cycles so both domains see several edges
        repeat (4) @(posedge i_line_clk);
        i_rstn <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        `CHK("clk_sel", 2'h0, clk_sel)
        `CHK("framer", 2'h1, fm)
        `CHK("op_mode", 2'h2, op)
        `CHK("cas_mf", 1'b1, cas_mf)
        go(5'h05, 8'h5A, 4'h6, 1'b1, 8'h3C, 4'hA);
        m.set_faults(5'h10);
        go(5'h05, 8'h5A, 4'h6, 1'b1, 8'hFF, 4'h1);
        `CHK("los_alarm", 1'b1, los_alarm)
        k = E1PM_CFG_RST;
        k.chan_en = 1'b0;
        k.clk_sel = E1PM_CLK_RECOVERED;
        k.idle_code = 8'h42;
        k.ts_map = 32'hFFFFFF7F;
        k.cond_byte = 8'hA5;
        k.conditioning_signal_nibble = 4'h9;
        apply(k);
        `CHK("los_off", 1'b0, los_alarm)
        `CHK("clk_sel", 2'h1, clk_sel)
        go(5'h05, 8'h5A, 4'h6, 1'b1, 8'h3C, 4'hA);
        go(5'h07, 8'h42, 4'h6, 1'b0, 8'h00, 4'hX);
        m.set_faults(5'h01);
        go(5'h05, 8'hA5, 4'h9, 1'b1, 8'h3C, 4'hA);
        m.set_faults(5'h00);
        k.chan_en = 1'b1;
        k.clk_sel = E1PM_CLK_INTERNAL;
        k.loop_mode = E1PM_LOOP_INTERNAL;
        apply(k);
        `CHK("clk_sel", 2'h2, clk_sel)
        go(5'h05, 8'hFF, 4'hF, 1'b1, 8'h5A, 4'h6);
        k.loop_mode = E1PM_LOOP_EXTERNAL;
        apply(k);
        go(5'h05, 8'h3C, 4'hA, 1'b1, 8'h3C, 4'hA);
        k.loop_mode = E1PM_LOOP_DISABLE;
        k.line_type = E1PM_LINE_CRC4_OFF;
        k.cas_en = 1'b0;
        apply(k);
        `CHK("line_off", 1'b0, line_on)
        go(5'h05, 8'hFF, 4'h0, 1'b0, 8'h00, 4'hX);
        apply(k);
        `CHK("line_on", 1'b1, line_on)
        `CHK("framer", 2'h2, fm)
        `CHK("op_mode", 2'h1, op)
        `CHK("cas_mf", 1'b0, cas_mf)
        go(5'h05, 8'h5A, 4'h0, 1'b1, 8'h3C, 4'h0);
        // framed frame-loss and alarm indication condition packets, nibble stays off
        m.set_faults(5'h0C);
        go(5'h05, 8'h5A, 4'h0, 1'b1, 8'hA5, 4'h0);
        k.line_type = E1PM_LINE_UNFRAMED;
        k.cas_en = 1'b1;
        apply(k);
        apply(k);
        `CHK("framer", 2'h0, fm)
        `CHK("op_mode", 2'h0, op)
        // frame-loss and alarm indication are still raised but mean nothing here
        go(5'h07, 8'h5A, 4'h0, 1'b1, 8'h3C, 4'h0);
        m.set_faults(5'h10);
        go(5'h07, 8'h5A, 4'h0, 1'b1, 8'hFF, 4'h0);
        m.set_faults(5'h01);
        go(5'h07, 8'hFF, 4'h0, 1'b1, 8'h3C, 4'h0);
        give_verdict();
    end
endmodule
